// *** stbct_consts.vh ***
/*
 * Constants for the two-bank SDRAM command and timing core.
 * Assumes the including module uses these names unchanged.
 */
`ifndef STBCT_CONSTS_VH
`define STBCT_CONSTS_VH

// Command codes as {ras_b, cas_b, we_b} with cs_b low
`define STBCT_CMD_MODE_LOAD 3'h0
`define STBCT_CMD_REFRESH 3'h1
`define STBCT_CMD_CLOSE 3'h2
`define STBCT_CMD_ROW_OPEN 3'h3
`define STBCT_CMD_WRITE 3'h4
`define STBCT_CMD_READ 3'h5
`define STBCT_CMD_HALT 3'h6
`define STBCT_CMD_NOP 3'h7

// Address pin roles
`define STBCT_BANK_BIT 11
`define STBCT_AP_BIT 10

// Operating-mode register fields
`define STBCT_MODE_BL_LSB 0
`define STBCT_MODE_BL_MSB 2
`define STBCT_MODE_BT_BIT 3
`define STBCT_MODE_CL_LSB 4
`define STBCT_MODE_CL_MSB 6
`define STBCT_MODE_WB_BIT 9
`define STBCT_MODE_RST 12'h030
`define STBCT_BL_FULL 3'h7
`define STBCT_CL2 3'h2

// Cycle counts
`define STBCT_T_RC_CL3 4'hA
`define STBCT_T_RC_CL2 4'h8
`define STBCT_T_MRD 4'h2

`endif

// *** stbct_sdram_core.v ***
/*
 * Two-bank synchronous DRAM command core: decodes commands on the
 * rising clock edge, tracks bank state, runs read and write bursts,
 * refresh and self-refresh, and drives the data pins.
 * Assumes the controller runs on the same clock and keeps its own
 * command spacing; the data pins are resolved outside from dq_oe.
 */
`timescale 1ns/1ps
`include "stbct_consts.vh"

module stbct_sdram_core #(
    parameter ROW_W = 11,
    parameter COL_W = 8
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Command pins
    input wire cke,
    input wire cs_b,
    input wire ras_b,
    input wire cas_b,
    input wire we_b,
    input wire [11:0] addr,
    input wire [1:0] dqm,
    // Data pins
    input wire [15:0] dq_in,
    output wire [15:0] dq_out,
    output wire [1:0] dq_oe,
    // Status
    output wire [1:0] bank_open,
    output wire mode_valid,
    output wire busy,
    output wire self_refresh,
    output wire cmd_reject,
    output wire [ROW_W-1:0] refresh_row
);

    // ------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------
    localparam AW = 1 + ROW_W + COL_W;

    reg [15:0] mem [0:(1 << AW) - 1]; // Cell array
    reg [ROW_W-1:0] row_reg [0:1]; // Open row per bank
    reg [11:0] mode_reg; // Operating mode
    reg mode_valid_reg; // Mode loaded once
    reg cke_prev_reg; // Clock enable last edge
    reg self_ref_reg; // In self-refresh
    reg [3:0] busy_cnt_reg; // Lockout cycles left
    reg [3:0] busy_next;
    reg busy_reg; // Lockout flag out
    reg [1:0] bank_open_reg; // Open banks
    reg [1:0] bank_open_next;
    reg bst_act_reg; // Burst running
    reg bst_wr_reg; // Burst is write
    reg bst_bank_reg; // Burst bank
    reg [COL_W-1:0] bst_col_reg; // Burst start column
    reg [COL_W-1:0] bst_cnt_reg; // Next word index
    reg bst_ap_reg; // Burst auto-closes
    reg close_pend_reg; // Auto-close due
    reg close_bank_reg; // Bank to auto-close
    reg [2:0] rd_vld_reg; // Read pipe valid
    reg [15:0] rd_dat0_reg; // Read pipe stage 0
    reg [15:0] rd_dat1_reg; // Read pipe stage 1
    reg [15:0] rd_dat2_reg; // Read pipe stage 2
    reg [1:0] dqm_d1_reg; // Mask delay 1
    reg [1:0] dqm_d2_reg; // Mask delay 2
    reg [15:0] dq_out_reg; // Data out
    reg [1:0] dq_oe_reg; // Byte drive enables
    reg reject_reg; // Refused command pulse
    reg [ROW_W-1:0] ref_row_reg; // Refresh row counter

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Wrap mask from burst length code
    function [COL_W-1:0] burst_mask;
        input [2:0] code;
        begin
            case (code)
                3'h0: burst_mask = {COL_W{1'b0}};
                3'h1: burst_mask = {{(COL_W-1){1'b0}}, 1'b1};
                3'h2: burst_mask = {{(COL_W-2){1'b0}}, 2'h3};
                3'h3: burst_mask = {{(COL_W-3){1'b0}}, 3'h7};
                default: burst_mask = {COL_W{1'b1}};
            endcase
        end
    endfunction

    // Column of word cnt, sequential or interleaved
    function [COL_W-1:0] burst_col;
        input [COL_W-1:0] start;
        input [COL_W-1:0] cnt;
        input [COL_W-1:0] mask;
        input ilv;
        begin
            if (ilv) begin
                burst_col = start ^ (cnt & mask);
            end else begin
                burst_col = (start & ~mask) | ((start + cnt) & mask);
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // Mode fields
    wire cl2 = (mode_reg[`STBCT_MODE_CL_MSB:`STBCT_MODE_CL_LSB] == `STBCT_CL2);
    wire [2:0] bl_code = mode_reg[`STBCT_MODE_BL_MSB:`STBCT_MODE_BL_LSB];
    wire single_wr = mode_reg[`STBCT_MODE_WB_BIT];
    wire [3:0] t_rc = cl2 ? `STBCT_T_RC_CL2 : `STBCT_T_RC_CL3;

    // Valid only with clock enable high last edge
    wire cmd_vld = cke_prev_reg & ~self_ref_reg & ~cs_b;
    wire [2:0] cmd = {ras_b, cas_b, we_b};
    wire cmd_bank = addr[`STBCT_BANK_BIT];
    wire cmd_ap = addr[`STBCT_AP_BIT];
    wire locked = |busy_cnt_reg;
    wire both_idle = ~|bank_open_reg;

    wire is_mrs = cmd_vld & (cmd == `STBCT_CMD_MODE_LOAD);
    wire is_ref = cmd_vld & (cmd == `STBCT_CMD_REFRESH);
    wire is_pre = cmd_vld & (cmd == `STBCT_CMD_CLOSE);
    wire is_act = cmd_vld & (cmd == `STBCT_CMD_ROW_OPEN);
    wire is_wr = cmd_vld & (cmd == `STBCT_CMD_WRITE);
    wire is_rd = cmd_vld & (cmd == `STBCT_CMD_READ);
    wire is_halt = cmd_vld & (cmd == `STBCT_CMD_HALT);
    wire is_nop = cmd_vld & (cmd == `STBCT_CMD_NOP);

    // Acceptance checks the device can see
    wire acc_mrs = is_mrs & ~locked & both_idle;
    wire acc_ref = is_ref & ~locked & both_idle;
    wire acc_pre = is_pre & ~locked;
    wire acc_act = is_act & ~locked & ~bank_open_reg[cmd_bank];
    wire acc_col = (is_rd | is_wr) & ~locked & bank_open_reg[cmd_bank];
    wire acc_halt = is_halt & ~locked;
    wire acc_any = acc_mrs | acc_ref | acc_pre | acc_act | acc_col | acc_halt;
    wire rejected = cmd_vld & ~is_nop & ~acc_any;

    // ------------------------------------------------------------
    // Burst word issue
    // ------------------------------------------------------------
    // Halt or a precharge of the burst bank stops the burst now
    wire kill = acc_halt | (acc_pre & (cmd_ap | (cmd_bank == bst_bank_reg)));
    // A new column command replaces the running burst
    wire cont = bst_act_reg & ~kill & ~acc_col;
    wire iss_vld = acc_col | cont;
    wire iss_wr = acc_col ? is_wr : bst_wr_reg;
    wire iss_bank = acc_col ? cmd_bank : bst_bank_reg;
    wire iss_ap = acc_col ? cmd_ap : bst_ap_reg;
    wire [COL_W-1:0] iss_start = acc_col ? addr[COL_W-1:0] : bst_col_reg;
    wire [COL_W-1:0] iss_cnt = acc_col ? {COL_W{1'b0}} : bst_cnt_reg;
    wire wr_one = iss_wr & single_wr;
    wire [COL_W-1:0] iss_mask = wr_one ? {COL_W{1'b0}} : burst_mask(bl_code);
    wire iss_full = (bl_code == `STBCT_BL_FULL) & ~wr_one;
    wire iss_last = ~iss_full & (iss_cnt == iss_mask);
    wire ilv = mode_reg[`STBCT_MODE_BT_BIT];
    wire [COL_W-1:0] iss_col = burst_col(iss_start, iss_cnt, iss_mask, ilv);
    wire [ROW_W-1:0] iss_row = iss_bank ? row_reg[1] : row_reg[0];
    wire [AW-1:0] mem_addr = {iss_bank, iss_row, iss_col};
    wire [15:0] mem_word = mem[mem_addr];

    // ------------------------------------------------------------
    // Next bank state and lockout
    // ------------------------------------------------------------
    // Bank open flags after this edge
    always @* begin
        bank_open_next = bank_open_reg;
        // Auto-close one cycle after the last word issues
        if (close_pend_reg) begin
            bank_open_next[close_bank_reg] = 1'b0;
        end
        if (acc_pre) begin
            if (cmd_ap) begin
                bank_open_next = 2'h0;
            end else begin
                bank_open_next[cmd_bank] = 1'b0;
            end
        end
        if (acc_act) begin
            bank_open_next[cmd_bank] = 1'b1;
        end
    end

    // Cycles in which commands are refused
    always @* begin
        busy_next = busy_cnt_reg;
        if (acc_ref & cke) begin
            busy_next = t_rc - 4'h1;
        end else if (acc_mrs) begin
            busy_next = `STBCT_T_MRD - 4'h1;
        end else if (self_ref_reg & cke) begin
            busy_next = t_rc - 4'h1;
        end else if (locked) begin
            busy_next = busy_cnt_reg - 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Mode, bank, refresh and burst state
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg <= `STBCT_MODE_RST;
            mode_valid_reg <= 1'b0;
            cke_prev_reg <= 1'b0;
            self_ref_reg <= 1'b0;
            busy_cnt_reg <= 4'h0;
            busy_reg <= 1'b0;
            bank_open_reg <= 2'h0;
            bst_act_reg <= 1'b0;
            bst_wr_reg <= 1'b0;
            bst_bank_reg <= 1'b0;
            bst_col_reg <= {COL_W{1'b0}};
            bst_cnt_reg <= {COL_W{1'b0}};
            bst_ap_reg <= 1'b0;
            close_pend_reg <= 1'b0;
            close_bank_reg <= 1'b0;
            reject_reg <= 1'b0;
            ref_row_reg <= {ROW_W{1'b0}};
        end else begin
            cke_prev_reg <= cke;
            busy_cnt_reg <= busy_next;
            busy_reg <= |busy_next;
            bank_open_reg <= bank_open_next;
            reject_reg <= rejected;
            // Mode load from the address pins
            if (acc_mrs) begin
                mode_reg <= addr;
                mode_valid_reg <= 1'b1;
            end
            // Self-refresh entry and exit follow clock enable
            if (acc_ref & ~cke) begin
                self_ref_reg <= 1'b1;
            end else if (self_ref_reg & cke) begin
                self_ref_reg <= 1'b0;
            end
            // Internal row address for refresh
            if (acc_ref & cke) begin
                ref_row_reg <= ref_row_reg + 1'b1;
            end
            // Burst progress
            bst_act_reg <= iss_vld & ~iss_last;
            if (iss_vld) begin
                bst_wr_reg <= iss_wr;
                bst_bank_reg <= iss_bank;
                bst_col_reg <= iss_start;
                bst_cnt_reg <= iss_cnt + 1'b1;
                bst_ap_reg <= iss_ap;
            end
            close_pend_reg <= iss_vld & iss_last & iss_ap;
            close_bank_reg <= iss_bank;
        end
    end

    // ------------------------------------------------------------
    // Cell array, open rows, read fetch
    // ------------------------------------------------------------
    // Writes take data and mask of the issue cycle
    always @(posedge clk) begin
        if (acc_act) begin
            row_reg[cmd_bank] <= addr[ROW_W-1:0];
        end
        if (iss_vld & iss_wr) begin
            mem[mem_addr] <= {dqm[1] ? mem_word[15:8] : dq_in[15:8],
                              dqm[0] ? mem_word[7:0] : dq_in[7:0]};
        end
        rd_dat0_reg <= mem_word;
        rd_dat1_reg <= rd_dat0_reg;
        rd_dat2_reg <= rd_dat1_reg;
    end

    // ------------------------------------------------------------
    // Read pipeline and data pins
    // ------------------------------------------------------------
    // Latency picks stage; mask acts two edges late
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_vld_reg <= 3'h0;
            dqm_d1_reg <= 2'h0;
            dqm_d2_reg <= 2'h0;
            dq_out_reg <= 16'h0000;
            dq_oe_reg <= 2'h0;
        end else begin
            rd_vld_reg <= {rd_vld_reg[1:0], iss_vld & ~iss_wr};
            dqm_d1_reg <= dqm;
            dqm_d2_reg <= dqm_d1_reg;
            if (cl2) begin
                dq_out_reg <= rd_dat1_reg;
                dq_oe_reg <= {2{rd_vld_reg[1]}} & ~dqm_d2_reg;
            end else begin
                dq_out_reg <= rd_dat2_reg;
                dq_oe_reg <= {2{rd_vld_reg[2]}} & ~dqm_d2_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign dq_out = dq_out_reg;
    assign dq_oe = dq_oe_reg;
    assign bank_open = bank_open_reg;
    assign mode_valid = mode_valid_reg;
    assign busy = busy_reg;
    assign self_refresh = self_ref_reg;
    assign cmd_reject = reject_reg;
    assign refresh_row = ref_row_reg;

endmodule

// *** stbct_sdram_monitor.sv ***
/* Checker for the SDRAM command core.
   Assumes it is bound onto the core and sees only its pins. */
`timescale 1ns/1ps
`include "stbct_consts.vh"
module stbct_sdram_monitor (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Command pins
    input wire cke,
    input wire cs_b,
    input wire ras_b,
    input wire cas_b,
    input wire we_b,
    input wire [11:0] addr,
    // Status
    input wire [1:0] dq_oe,
    input wire [1:0] bank_open,
    input wire mode_valid,
    input wire busy,
    input wire self_refresh,
    input wire cmd_reject
);
// ------------------------------
// Command decode
// ------------------------------
reg cke_q; // Clock enable one edge back
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        cke_q <= 1'h0;
    end else begin
        cke_q <= cke;
    end
end
wire [2:0] code = {ras_b, cas_b, we_b};
wire take = !cs_b && cke_q && !self_refresh; // Command seen by the core
wire free = take && !busy; // Not refused for busy
wire idle = bank_open == 2'h0; // Both banks closed
default clocking @(posedge clk); endclocking
default disable iff (!rst_b);
// ------------------------------
// Properties
// ------------------------------
mode_busy_a: assert property (
    free && idle && code == `STBCT_CMD_MODE_LOAD |=> busy ##1 !busy)
    else $error("mode load quiet time wrong");
mode_valid_a: assert property (
    free && idle && code == `STBCT_CMD_MODE_LOAD |=> mode_valid)
    else $error("mode load not taken");
refresh_busy_a: assert property (
    free && idle && cke && code == `STBCT_CMD_REFRESH |=> busy [*7])
    else $error("refresh row cycle too short");
self_entry_a: assert property (
    free && idle && !cke && code == `STBCT_CMD_REFRESH |=> self_refresh)
    else $error("self refresh not entered");
row_open_a: assert property (
    free && code == `STBCT_CMD_ROW_OPEN && !bank_open[addr[11]]
    |=> bank_open[$past(addr[11])])
    else $error("bank not opened");
close_all_a: assert property (
    free && code == `STBCT_CMD_CLOSE && addr[10] |=> bank_open == 2'h0)
    else $error("close of both banks failed");
close_one_a: assert property (
    free && code == `STBCT_CMD_CLOSE && !addr[10] |=> !bank_open[$past(addr[11])])
    else $error("close of one bank failed");
busy_refuse_a: assert property (
    take && busy && code != `STBCT_CMD_NOP |=> cmd_reject)
    else $error("command during busy not refused");
closed_col_a: assert property (
    free && code[2:1] == 2'h2 && !bank_open[addr[11]] |=> cmd_reject)
    else $error("column command to closed bank not refused");
ref_c: cover property (free && cke && code == `STBCT_CMD_REFRESH);
read_c: cover property (dq_oe == 2'h3);
self_c: cover property ($rose(self_refresh));
rej_c: cover property (cmd_reject);
endmodule

// *** stbct_ctrl_model.sv ***
/* Controller model driving the SDRAM command and data pins.
   Assumes callers enter its tasks one step after a rising edge. */
`timescale 1ns/1ps
`include "stbct_consts.vh"
module stbct_ctrl_model (
    // Clock
    input wire clk,
    // Pins towards the memory
    output reg cke,
    output reg cs_b,
    output reg ras_b,
    output reg cas_b,
    output reg we_b,
    output reg [11:0] addr,
    output reg [1:0] dqm,
    output reg [15:0] dq_in
);
// Quiet pins at time zero
initial begin
    cke = 1'h1;
    cs_b = 1'h0;
    {ras_b, cas_b, we_b} = `STBCT_CMD_NOP;
    addr = 12'h000;
    dqm = 2'h0;
    dq_in = 16'h0000;
end
// One command, sampled at the next edge; write word rides with it
task cmd(input k, input [2:0] c, input [11:0] a, input [1:0] m, input [15:0] d);
    begin
        cke = k;
        cs_b = 1'h0;
        {ras_b, cas_b, we_b} = c;
        addr = a;
        dqm = m;
        dq_in = d;
        @(posedge clk);
        #1;
    end
endtask
// Quiet cycles; stale data lines keep toggling
task idle(input integer n);
    begin
        {ras_b, cas_b, we_b} = `STBCT_CMD_NOP;
        dqm = 2'h0;
        addr = ~addr;
        repeat (n) begin
            dq_in = ~dq_in;
            cs_b = $urandom; // Deselect is a quiet cycle as well
            @(posedge clk);
            #1;
        end
    end
endtask
endmodule

// *** sdram_two_bank_command_timing_tb.sv ***
/* Self-checking bench for the SDRAM command core.
   Assumes the core, its constants header and the controller model. */
`timescale 1ns/1ps
`include "stbct_consts.vh"
module sdram_two_bank_command_timing_tb;
reg clk = 1'h0;
reg rst_b = 1'h0;
wire cke, cs_b, ras_b, cas_b, we_b, mode_valid, busy, self_refresh, cmd_reject;
wire [11:0] addr;
wire [1:0] dqm, dq_oe, bank_open;
wire [15:0] dq_in, dq_out;
wire [3:0] refresh_row;
integer err_count = 0;
integer checked = 0;
integer cl, n, i, r;
reg b;
reg [10:0] row;
reg [3:0] c;
reg [15:0] d0, d1, d2, w0, z;
reg [1:0] mk;
stbct_ctrl_model ctrl_inst (.clk(clk), .cke(cke), .cs_b(cs_b), .ras_b(ras_b),
    .cas_b(cas_b), .we_b(we_b), .addr(addr), .dqm(dqm), .dq_in(dq_in));
stbct_sdram_core #(.ROW_W(4), .COL_W(4)) stbct_sdram_core_inst (.clk(clk), .rst_b(rst_b),
    .cke(cke), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .addr(addr),
    .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .bank_open(bank_open),
    .mode_valid(mode_valid), .busy(busy), .self_refresh(self_refresh),
    .cmd_reject(cmd_reject), .refresh_row(refresh_row));
// 50 MHz clock
initial begin
    forever #10 clk = ~clk;
end
// Mode word: latency, burst of two, sequential
function [11:0] mw(input [2:0] lat);
    mw = {5'h00, lat, 4'h1};
endfunction
// Stored word after a masked write
function [15:0] mix(input [15:0] old, input [15:0] nw, input [1:0] m);
    mix = {m[1] ? old[15:8] : nw[15:8], m[0] ? old[7:0] : nw[7:0]};
endfunction
task chk(input [15:0] seen, input [15:0] exp);
    begin
        checked = checked + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
endtask
task wrap_up;
    begin
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    end
endtask
// Count busy cycles, bounded
task busy_run(input integer k);
    begin
        n = k;
        while (busy === 1'h1 && n < 20) begin
            ctrl_inst.idle(1);
            n = n + 1;
        end
        // Bound used up: count it and close the run
        if (n == 20) begin
            err_count = err_count + 1;
            wrap_up;
        end
    end
endtask
// Hang guard
initial begin
    #1000000;
    err_count = err_count + 1;
    wrap_up;
end
// Main sequence, once per latency
initial begin
    r = $urandom(14);
    repeat (2) @(posedge clk);
    #1 rst_b = 1'h1;
    chk(bank_open, 2'h0);
    chk(dq_oe, 2'h0);
    ctrl_inst.idle(1);
    for (i = 0; i < 2; i = i + 1) begin
        cl = 3 - i;
        b = $urandom;
        row = $urandom;
        c = $urandom;
        c[0] = 1'h0;
        d0 = $urandom;
        d1 = $urandom;
        d2 = $urandom;
        z = $urandom;
        mk = $urandom;
        w0 = mix(d0, d2, mk);
        // Masks and data are don't-care on these commands
        ctrl_inst.cmd(1'h1, `STBCT_CMD_CLOSE, 12'h400, mk, z);
        ctrl_inst.idle(cl - 1);
        ctrl_inst.cmd(1'h1, `STBCT_CMD_MODE_LOAD, mw(cl[2:0]), mk, z);
        ctrl_inst.idle(1);
        chk(mode_valid, 1'h1);
        ctrl_inst.cmd(1'h1, `STBCT_CMD_ROW_OPEN, {b, row}, mk, z);
        chk(bank_open[b], 1'h1);
        ctrl_inst.idle(cl - 1);
        ctrl_inst.cmd(1'h1, `STBCT_CMD_WRITE, {b, 7'h00, c}, 2'h0, d0);
        ctrl_inst.cmd(1'h1, `STBCT_CMD_NOP, z[11:0], 2'h0, d1);
        ctrl_inst.cmd(1'h1, `STBCT_CMD_WRITE, {b, 7'h00, c}, mk, d2);
        ctrl_inst.cmd(1'h1, `STBCT_CMD_NOP, z[11:0], 2'h3, ~d2);
        ctrl_inst.idle(1);
        // Read with auto-close; mask two edges before the first word
        ctrl_inst.cmd(1'h1, `STBCT_CMD_READ, {b, 7'h40, c}, (cl == 2) ? 2'h2 : 2'h0, z);
        ctrl_inst.cmd(1'h1, `STBCT_CMD_NOP, z[11:0], (cl == 3) ? 2'h2 : 2'h0, z);
        ctrl_inst.idle(cl - 1);
        chk(dq_oe, 2'h1);
        chk(dq_out[7:0], w0[7:0]);
        ctrl_inst.idle(1);
        chk(dq_out, d1);
        ctrl_inst.idle(3);
        chk(bank_open[b], 1'h0);
        // Halt one cycle into a read; other bank opened on the way
        ctrl_inst.cmd(1'h1, `STBCT_CMD_ROW_OPEN, {b, row}, 2'h0, z);
        ctrl_inst.idle(1);
        ctrl_inst.cmd(1'h1, `STBCT_CMD_ROW_OPEN, {~b, row}, 2'h0, z);
        ctrl_inst.idle(1);
        chk(bank_open, 2'h3);
        ctrl_inst.cmd(1'h1, `STBCT_CMD_READ, {b, 7'h00, c}, 2'h0, z);
        ctrl_inst.cmd(1'h1, `STBCT_CMD_HALT, z[11:0], 2'h0, z);
        ctrl_inst.idle(cl - 1);
        chk(dq_out, w0);
        chk(dq_oe, 2'h3);
        ctrl_inst.idle(1);
        chk(dq_oe, 2'h0);
        // Refused commands: activate of an open bank, read of a closed one
        ctrl_inst.cmd(1'h1, `STBCT_CMD_ROW_OPEN, {b, row}, 2'h0, z);
        chk(cmd_reject, 1'h1);
        ctrl_inst.cmd(1'h1, `STBCT_CMD_CLOSE, {b, 11'h400}, 2'h0, z);
        chk(bank_open, 2'h0);
        ctrl_inst.cmd(1'h1, `STBCT_CMD_READ, {~b, 7'h00, c}, 2'h0, z);
        chk(cmd_reject, 1'h1);
        ctrl_inst.idle(cl - 1);
        // Refresh with an activate thrown into the row cycle
        ctrl_inst.cmd(1'h1, `STBCT_CMD_REFRESH, z[11:0], mk, z);
        ctrl_inst.cmd(1'h1, `STBCT_CMD_ROW_OPEN, {b, row}, 2'h0, z);
        busy_run(1);
        chk(n[15:0], (cl == 3) ? 16'h0009 : 16'h0007);
        chk(bank_open, 2'h0);
        chk(refresh_row, i[15:0] + 16'h0001);
        // Self refresh in and out
        ctrl_inst.cmd(1'h0, `STBCT_CMD_REFRESH, z[11:0], 2'h0, z);
        ctrl_inst.idle(4);
        chk(self_refresh, 1'h1);
        ctrl_inst.cmd(1'h1, `STBCT_CMD_NOP, z[11:0], 2'h0, z);
        chk(self_refresh, 1'h0);
        busy_run(0);
        chk(n[15:0], (cl == 3) ? 16'h0009 : 16'h0007);
    end
    wrap_up;
end
endmodule
bind stbct_sdram_core stbct_sdram_monitor stbct_sdram_monitor_inst (.clk(clk), .rst_b(rst_b),
    .cke(cke), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .addr(addr),
    .dq_oe(dq_oe), .bank_open(bank_open), .mode_valid(mode_valid), .busy(busy),
    .self_refresh(self_refresh), .cmd_reject(cmd_reject));
